// ### tio_map.svh
`ifndef TIO_MAP_SVH
`define TIO_MAP_SVH

// Port address, compared against the low address byte only
`define TIO_PORT_ADDR        8'hFF
// Output latch: width, reset value and bit positions
`define TIO_LATCH_W          4
`define TIO_LATCH_RST        4'h0
`define TIO_BIT_AUDIO0       0
`define TIO_BIT_AUDIO1       1
`define TIO_BIT_MOTOR        2
`define TIO_BIT_WIDTH        3
// Data bus bit that carries the cassette input capture latch on a read
`define TIO_BIT_CAPTURE      7
// Synchroniser depth for pin inputs
`define TIO_SYNC_STAGES      3

`endif

// ### tio_pkg.sv
`default_nettype none

package tio_pkg;

  // Tape audio output level, from latched bits 1:0
  typedef enum logic [1:0] {
    TIO_LVL_MID  = 2'b00,
    TIO_LVL_HIGH = 2'b01,
    TIO_LVL_LOW  = 2'b10
  } tio_level_t;

  // Three-stage synchroniser plus the filtered value
  typedef struct packed {
    logic [2:0] stg;
    logic       filt;
  } tio_sync_t;

  // Whole state of the port
  typedef struct packed {
    tio_sync_t [7:0] addr;
    tio_sync_t [3:0] data;
    tio_sync_t       out_req_n;
    tio_sync_t       in_req_n;
    tio_sync_t       tape_pulse_n;
    logic            port_write_strobe_n;
    logic            port_read_strobe_n;
    logic [3:0]      latch;
    tio_level_t      level;
    logic            capture;
    logic [7:0]      rdata;
    logic            rdata_oe;
  } tio_state_t;

endpackage : tio_pkg

`default_nettype wire

// ### tio_port.sv
// Functional notes
// R1 - Port selected only when low eight address bits equal FF.
// R2 - Write strobe low while output request and port select are low.
// R3 - Read strobe low while input request and port select are low.
// R4 - Processor never asserts input and output requests together.
// R5 - Data bits 0 to 3 latched on each write strobe rising edge.
// R6 - Latched bit 2 drives the recorder motor relay, high runs it.
// R7 - Latched bit 3 drives the display character width select.
// R8 - Latched bits 1:0 set tape audio: 00 middle, 01 high, 10 low.
// R9 - Software makes all tape audio timing by successive writes.
// R10 - Software starts the motor before writing tape audio.
// R11 - Each recorded bit cell lasts 2 ms between start pulses.
// R12 - A one has a mid-cell pulse at 1 ms; a zero has none.
// R13 - A save starts with 128 zero bits then sync byte A5.
// R14 - Then two-byte start address, two-byte end address, data bytes.
// R15 - Record ends with a sum-of-data checksum; mismatch is load error.
// R16 - After a save software disables audio and stops the motor.
// R17 - Write strobe also clears the cassette input capture latch.
// R18 - Capture latch set by tape pulse, read onto data bus on port read.
// R19 - At reset the output latch clears to zero.
`include "tio_map.svh"
`default_nettype none

module tio_port (
  input  wire logic               mclk_i,                 // 100 MHz system clock
  input  wire logic               nrst_i,                 // Async reset, active low
  input  wire logic [7:0]         addr_i,                 // Processor address, low byte
  input  wire logic [3:0]         data_i,                 // Processor data bus bits 3:0
  input  wire logic               out_req_n_i,            // Output request, active low
  input  wire logic               in_req_n_i,             // Input request, active low
  input  wire logic               tape_pulse_n_i,         // Detected tape pulse, active low
  output logic                    port_write_strobe_n_o,  // Port write strobe, active low
  output logic                    port_read_strobe_n_o,   // Port read strobe, active low
  output logic                    motor_o,                // Recorder motor relay drive
  output logic                    char_width_select_o,    // Display width select
  output tio_pkg::tio_level_t     tape_audio_out_o,       // Tape audio level
  output logic                    capture_o,              // Capture latch state
  output logic [7:0]              data_o,                 // Data bus drive value
  output logic                    data_oe_o               // Data bus drive enable
);
  import tio_pkg::*;

  tio_state_t st_r;
  tio_state_t st_nxt;

  // Shift a pin into its synchroniser; the filtered value follows only once
  // stages two and three agree, so the first stage feeds nothing but the second
  function automatic tio_sync_t sync_step(input tio_sync_t s, input logic pin);
    tio_sync_t r;
    r.stg  = {s.stg[1:0], pin};
    r.filt = (s.stg[1] == s.stg[2]) ? s.stg[2] : s.filt;
    return r;
  endfunction

  // Level code decode; the unused 11 code is parked at the middle level
  function automatic tio_level_t level_of(input logic [1:0] code);
    case (code)
      2'b01:   return TIO_LVL_HIGH;
      2'b10:   return TIO_LVL_LOW;
      default: return TIO_LVL_MID;
    endcase
  endfunction

  logic sel;

  // Next state
  always_comb begin
    st_nxt = st_r;
    for (int i = 0; i < 8; i++) begin
      st_nxt.addr[i] = sync_step(st_r.addr[i], addr_i[i]);
    end
    for (int i = 0; i < 4; i++) begin
      st_nxt.data[i] = sync_step(st_r.data[i], data_i[i]);
    end
    st_nxt.out_req_n    = sync_step(st_r.out_req_n, out_req_n_i);
    st_nxt.in_req_n     = sync_step(st_r.in_req_n, in_req_n_i);
    st_nxt.tape_pulse_n = sync_step(st_r.tape_pulse_n, tape_pulse_n_i);

    // Higher address bits never reach the decoder
    sel = ({st_r.addr[7].filt, st_r.addr[6].filt, st_r.addr[5].filt,
            st_r.addr[4].filt, st_r.addr[3].filt, st_r.addr[2].filt,
            st_r.addr[1].filt, st_r.addr[0].filt} == `TIO_PORT_ADDR);  // see R1
    st_nxt.port_write_strobe_n = ~(~st_r.out_req_n.filt & sel);      // see R2
    st_nxt.port_read_strobe_n  = ~(~st_r.in_req_n.filt & sel);       // see R3

    // Latch on the strobe's rising edge; data was stable while it was low
    if (!st_r.port_write_strobe_n && st_nxt.port_write_strobe_n) begin
      st_nxt.latch = {st_r.data[3].filt, st_r.data[2].filt,
                      st_r.data[1].filt, st_r.data[0].filt};          // see R5
      st_nxt.level = level_of({st_r.data[1].filt, st_r.data[0].filt}); // see R8
    end

    // Pulse sets, write strobe clears; a pulse in the clearing cycle wins
    if (!st_r.tape_pulse_n.filt) begin
      st_nxt.capture = 1'b1;                                         // see R18
    end else if (!st_r.port_write_strobe_n) begin
      st_nxt.capture = 1'b0;                                         // see R17
    end

    // Drive the capture state on the bus for the whole read strobe
    st_nxt.rdata_oe = ~st_nxt.port_read_strobe_n;                    // see R18
    st_nxt.rdata    = 8'h00;
    st_nxt.rdata[`TIO_BIT_CAPTURE] = st_r.capture;
  end

  // State register
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= '0;
      st_r.addr                <= '0;
      st_r.data                <= '0;
      st_r.out_req_n           <= '{stg: 3'h7, filt: 1'b1};
      st_r.in_req_n            <= '{stg: 3'h7, filt: 1'b1};
      st_r.tape_pulse_n        <= '{stg: 3'h7, filt: 1'b1};
      st_r.port_write_strobe_n <= 1'b1;
      st_r.port_read_strobe_n  <= 1'b1;
      st_r.latch               <= `TIO_LATCH_RST;                    // see R19
      st_r.level               <= TIO_LVL_MID;                       // see R19
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state flops
  assign port_write_strobe_n_o = st_r.port_write_strobe_n;
  assign port_read_strobe_n_o  = st_r.port_read_strobe_n;
  assign motor_o               = st_r.latch[`TIO_BIT_MOTOR];         // see R6
  assign char_width_select_o   = st_r.latch[`TIO_BIT_WIDTH];         // see R7
  assign tape_audio_out_o      = st_r.level;                         // see R8
  assign capture_o             = st_r.capture;
  assign data_o                = st_r.rdata;
  assign data_oe_o             = st_r.rdata_oe;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_write_rise;
    !port_write_strobe_n_o ##1 port_write_strobe_n_o;
  endsequence

  sequence s_read_open;
    $fell(port_read_strobe_n_o);
  endsequence

  AST_SEL_ADDR: assert property (!port_write_strobe_n_o |-> $past(sel)) // see R1
    else $error("Write strobe without port address");
  AST_WR_STROBE: assert property ((!st_r.out_req_n.filt && sel) |=> !port_write_strobe_n_o) // see R2
    else $error("Write strobe missing on output cycle");
  AST_RD_STROBE: assert property ((!st_r.in_req_n.filt && sel) |=> !port_read_strobe_n_o) // see R3
    else $error("Read strobe missing on input cycle");
  AST_LATCH_HOLD: assert property (!$rose(port_write_strobe_n_o) |-> $stable(st_r.latch)) // see R5
    else $error("Output latch changed without a write");
  AST_LATCH_LOAD: assert property (s_write_rise |->
                                   st_r.latch == {$past(st_r.data[3].filt), $past(st_r.data[2].filt),
                                                  $past(st_r.data[1].filt),
                                                  $past(st_r.data[0].filt)}) // see R5
    else $error("Output latch did not load");
  AST_MOTOR: assert property (s_write_rise |=> motor_o == $past(st_r.data[2].filt, 2)) // see R6
    else $error("Motor output not taken from data bit 2");
  AST_WIDTH: assert property (s_write_rise |=> char_width_select_o == $past(st_r.data[3].filt, 2)) // see R7
    else $error("Width select not taken from data bit 3");
  AST_LEVEL: assert property (s_write_rise |=>
                              tape_audio_out_o == level_of({$past(st_r.data[1].filt, 2),
                                                            $past(st_r.data[0].filt, 2)})) // see R8
    else $error("Tape audio level wrong");
  AST_CLEAR: assert property ((!port_write_strobe_n_o && st_r.tape_pulse_n.filt) |=> !capture_o) // see R17
    else $error("Capture latch not cleared by write");
  AST_SET: assert property (!st_r.tape_pulse_n.filt |=> capture_o) // see R18
    else $error("Capture latch not set by tape pulse");
  AST_READ: assert property (s_read_open |-> data_oe_o ##0 data_o[7] == $past(capture_o)) // see R18
    else $error("Read does not drive capture state");
  AST_RESET: assert property ($rose(nrst_i) |-> st_r.latch == 4'h0) // see R19
    else $error("Latch not cleared at reset");

  // Exclusive requests must never give two strobes; a glitchy decoder would
  AST_EXCL: assert property (!(!port_write_strobe_n_o && !port_read_strobe_n_o)) // see R4
    else $error("Both port strobes low together");

  // Bus drive follows the read strobe exactly, so no contention after a read
  AST_OE: assert property (data_oe_o == !port_read_strobe_n_o) // see R18
    else $error("Bus drive enable differs from read strobe");

  // Only the capture bit is reported; the rest of the byte reads as zero
  AST_RD_LOW_BITS: assert property (data_oe_o |-> data_o[6:0] == 7'h00) // see R18
    else $error("Unused read data bits not zero");

  // Any other address leaves both strobes high
  AST_NO_SEL: assert property (!$past(sel) |-> port_write_strobe_n_o && port_read_strobe_n_o) // see R1
    else $error("Strobe without port address");

  // Once set, the capture latch stays set until a write clears it
  AST_CAP_STAY: assert property ((capture_o && st_r.port_write_strobe_n) |=> capture_o) // see R18
    else $error("Capture latch dropped without a write");

  // Without a tape pulse a clear capture latch stays clear
  AST_CAP_IDLE: assert property ((!capture_o && st_r.tape_pulse_n.filt) |=> !capture_o) // see R18
    else $error("Capture latch set without a tape pulse");

  // Width select only moves on a write strobe rising edge
  AST_WIDTH_HOLD: assert property (!$rose(port_write_strobe_n_o) |-> $stable(char_width_select_o)) // see R7
    else $error("Width select moved without a write");

  // Audio level only moves on a write, so software alone sets its timing
  AST_AUDIO_HOLD: assert property (!$rose(port_write_strobe_n_o) |-> $stable(tape_audio_out_o)) // see R8
    else $error("Audio level moved without a write");

  // Motor relay only moves on a write
  AST_MOTOR_HOLD: assert property (!$rose(port_write_strobe_n_o) |-> $stable(motor_o)) // see R6
    else $error("Motor moved without a write");

  // Both requests idle close both strobes on the next edge
  AST_RELEASE: assert property ((st_r.out_req_n.filt && st_r.in_req_n.filt)
                                |=> port_write_strobe_n_o && port_read_strobe_n_o) // see R2, R3
    else $error("Strobe held after request released");

  // The bus is let go on the edge where the read strobe returns high
  AST_RD_CLOSE: assert property ($rose(port_read_strobe_n_o) |-> !data_oe_o) // see R18
    else $error("Bus still driven after read");

  // The unused level code is parked, never shown on the audio output
  AST_LEVEL_CODE: assert property (tape_audio_out_o != 2'b11) // see R8
    else $error("Unused audio level code on output");

endmodule // tio_port

`default_nettype wire

// ### tio_tape.sv
`default_nettype none
// Recorder model: plays back one tape pulse on request, only while the motor runs
module tio_tape (
  input  wire logic mclk_i,          // System clock
  input  wire logic play_i,          // Request one playback pulse
  input  wire logic motor_i,         // Motor relay drive from the port
  output logic      tape_pulse_n_o   // Detected pulse, active low
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  // A stopped motor gives no pulses; long enough to pass the 3-flop filter
  always @(posedge mclk_i) begin
    if (play_i && motor_i) cnt <= 5;
    else if (cnt > 0) cnt <= cnt - 1;
  end
  assign tape_pulse_n_o = (cnt == 0);
endmodule // tio_tape
`default_nettype wire

// ### test_tio_port.sv
`default_nettype none
module test_tio_port;
  import tio_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 0, nrst_i = 0, out_req_n = 1, in_req_n = 1, play = 0, tp_n, wst, rst_s;
  logic motor, width, oe, cap, pw = 0, po = 0;
  logic [7:0] addr = 8'h00, dout;
  logic [3:0] data = 4'h0;
  tio_level_t aud;
  logic [7:0] expq[$];
  int err_count = 0, checks_done = 0, cyc = 0, seed = 90;
  tio_port i_dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr), .data_i(data),
    .out_req_n_i(out_req_n), .in_req_n_i(in_req_n), .tape_pulse_n_i(tp_n),
    .port_write_strobe_n_o(wst), .port_read_strobe_n_o(rst_s), .motor_o(motor),
    .char_width_select_o(width), .tape_audio_out_o(aud), .capture_o(cap),
    .data_o(dout), .data_oe_o(oe));
  tio_tape i_tape (.mclk_i(mclk_i), .play_i(play), .motor_i(motor), .tape_pulse_n_o(tp_n));
  initial forever #5 mclk_i = ~mclk_i;
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Requests are never overlapped, so both strobes never go low together
  task automatic cycle(input logic wr, input logic [7:0] a, input logic [3:0] d);
    @(negedge mclk_i);
    addr = a;
    data = d;
    repeat (4) @(negedge mclk_i);
    if (wr) out_req_n = 0;
    else in_req_n = 0;
    repeat (6) @(negedge mclk_i);
    check("wstrobe", {7'h0, wst}, {7'h0, !(wr && a == 8'hFF)});
    check("rstrobe", {7'h0, rst_s}, {7'h0, !(!wr && a == 8'hFF)});
    out_req_n = 1;
    in_req_n = 1;
    repeat (6) @(negedge mclk_i);
  endtask
  // Notes the latch value that the rules give for a code, then writes it
  task automatic put(input logic [3:0] d);
    expq.push_back({4'h0, d[2], d[3], (d[1:0] == 2'b11 ? 2'b00 : d[1:0])});
    cycle(1, 8'hFF, d);
  endtask
  // One start pulse: high, low, back to middle, motor kept running
  task automatic tape_pulse();
    put(4'h5);
    put(4'h6);
    put(4'h4);
  endtask
  // Bit cell, shortened to bench time: start pulse, and a mid-cell pulse for a one
  task automatic save_bit(input logic b);
    tape_pulse();
    if (b) tape_pulse();
    repeat (4) @(negedge mclk_i);
  endtask
  task automatic save_byte(input logic [7:0] v);
    for (int k = 7; k >= 0; k--) save_bit(v[k]);
  endtask
  // Results are compared when they show: strobe rise for writes, drive start for reads
  always @(negedge mclk_i) begin
    if (pw && wst) check("latch", {4'h0, motor, width, aud}, expq.pop_front());
    if (!po && oe) check("rdata", dout, expq.pop_front());
    pw <= !wst;
    po <= oe;
  end
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      print_verdict();
    end
  end
  initial begin
    logic [3:0] d;
    logic [7:0] a;
    logic [7:0] sum;
    repeat (2) @(negedge mclk_i);
    nrst_i = 1;
    @(negedge mclk_i);
    check("rst", {1'b0, cap, oe, 1'b0, motor, width, aud}, 8'h00);
    // Every audio code, motor and width bits random; motor runs before audio
    for (int i = 0; i < 8; i++) begin
      d = 4'($random(seed));
      d[1:0] = i[1:0];
      if (i == 0) d[2] = 1;
      put(d);
    end
    // Low address bit clear: not the port, latch must not move
    a = 8'($random(seed));
    a[0] = 0;
    cycle(1, a, 4'hF);
    check("hold", {4'h0, motor, width, aud}, {4'h0, d[2], d[3], 2'b00});
    put(4'h4);
    expq.push_back(8'h80);
    @(negedge mclk_i) play = 1;
    @(negedge mclk_i) play = 0;
    repeat (10) @(negedge mclk_i);
    cycle(0, 8'hFF, 4'h0);
    put(4'h4);
    expq.push_back(8'h00);
    cycle(0, 8'hFF, 4'h0);
    // Short record: leader, sync, addresses, two data bytes, checksum, motor off
    for (int i = 0; i < 128; i++) save_bit(1'b0);
    save_byte(8'hA5);
    save_byte(8'h42);
    save_byte(8'h00);
    save_byte(8'h42);
    save_byte(8'h01);
    sum = 8'h3C + 8'hC9;
    save_byte(8'h3C);
    save_byte(8'hC9);
    save_byte(sum);
    put(4'h0);
    check("queue", 8'(expq.size()), 8'h00);
    print_verdict();
  end
endmodule // test_tio_port
`default_nettype wire
